/* File: hdl/bca_cfg.svh */
`ifndef BCA_CFG_SVH
`define BCA_CFG_SVH
`define BCA_CLK_HZ        50000000
`define BCA_OSC_DIV       32768
`define BCA_NET_MAX       8'hFF
`define BCA_NET_FULL      8'h64
`define BCA_TOT_MAX       16'hFFFF
`define BCA_NET_STEP      18'h00021
`define BCA_TOT_STEP      18'h00D25
`define BCA_CFG_CONV_BIT  0
`define BCA_CFG_TOT_BIT   1
`define BCA_CFG_SHAD_BIT  2
`define BCA_DISC_SEC      1
`endif

/* File: hdl/bca_pkg.sv */
`default_nettype none
package bca_pkg;
   typedef enum logic [1:0] {
      BCA_TOT_OFF,
      BCA_TOT_VOLATILE,
      BCA_TOT_SHADOW
   } bca_tot_mode_t;
endpackage
`default_nettype wire

/* File: hdl/bca_sec_counter.sv */
`include "bca_cfg.svh"
`default_nettype none
module bca_sec_counter (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        osc_tick,
   output logic [31:0]      seconds,
   output logic             sec_pulse
);
   logic [14:0] div_ff;
   logic [31:0] sec_ff;
   logic        pulse_ff;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_ff   <= 15'h0000;
         sec_ff   <= 32'h00000000;
         pulse_ff <= 1'b0;
      end else begin
         pulse_ff <= 1'b0;
         if (osc_tick) begin
            div_ff <= div_ff + 15'h0001; // (R24)
            if (div_ff == 15'h7FFF) begin
               sec_ff   <= sec_ff + 32'h00000001; // (R16)
               pulse_ff <= 1'b1;
            end
         end
      end
   end

   assign seconds   = sec_ff;
   assign sec_pulse = pulse_ff;

   property p_sec_step;
      @(posedge clk_sys) disable iff (rst)
         (osc_tick && div_ff == 15'h7FFF) |=> sec_ff == $past(sec_ff) + 1;
   endproperty
   a_sec_step: assert property (p_sec_step) // (R24)
      else $error("seconds did not advance on divider wrap");
endmodule
`default_nettype wire

/* File: hdl/bca_accum.sv */
`include "bca_cfg.svh"
`default_nettype none
// Operation
// (R01) Each sample moves net and lifetime totals
// (R02) Net counter eight bits, 0.01C step
// (R03) Net counter saturates at 255
// (R04) Host reloads net counter to 100
// (R05) Net counter moves only when converter enabled
// (R06) Charge total 16 bits, positive current only
// (R07) Discharge total 16 bits, negative current only
// (R08) Shadow request per 0.32C step; totals here step every 3365 counts, about 102 net steps of 33 counts
// (R09) Disabled mode accumulates no totals
// (R10) Volatile mode accumulates, never shadows
// (R11) Shadow mode writes each total per step
// (R12) Host never writes totals page; chg_load and dis_load here let the host load both totals
// (R13) Empty net counter keeps totals
// (R14) Seconds timebase from 32.768 kHz oscillator
// (R15) Snapshot time on recall command bit
// (R16) Thirty-two bit seconds, wraps
// (R17) Line low over 1 s stamps disconnect
// (R18) Sleep halts all but seconds
// (R19) Charge reversal stamps end of charge
// (R20) Config bit 0 enables converter, net
// (R21) Config bit 1 enables lifetime totals
// (R22) Config bit 2 selects shadowing
// (R23) Fractional accumulators keep remainders
// (R24) Seconds advance every 32768 oscillator cycles
module bca_accum (
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire logic               sample_tick,
   input  wire logic signed [9:0]  sample_current,
   input  wire logic [7:0]         config_byte,
   input  wire logic               osc_tick,
   input  wire logic               line_in,
   input  wire logic               recall_bit8,
   input  wire logic               net_load,
   input  wire logic [7:0]         net_load_val,
   input  wire logic               chg_load,
   input  wire logic [15:0]        chg_load_val,
   input  wire logic               dis_load,
   input  wire logic [15:0]        dis_load_val,
   output logic [7:0]              net_capacity_counter,
   output logic [15:0]             lifetime_charge_total,
   output logic [15:0]             lifetime_discharge_total,
   output logic                    shadow_charge_req,
   output logic                    shadow_discharge_req,
   output logic [31:0]             seconds_live,
   output logic [31:0]             seconds_hold,
   output logic [31:0]             disconnect_stamp,
   output logic [31:0]             end_charge_stamp,
   output logic                    sleeping
);
   logic        current_converter_enable;
   logic        lifetime_totals_enable;
   logic        totals_shadow_select;
   bca_pkg::bca_tot_mode_t mode;
   logic [31:0] seconds;
   logic        sec_pulse;
   logic [7:0]  net_ff;
   logic [15:0] chg_ff;
   logic [15:0] dis_ff;
   logic [17:0] net_frac_ff;
   logic [17:0] chg_frac_ff;
   logic [17:0] dis_frac_ff;
   logic [17:0] mag;
   logic        pos;
   logic        neg;
   logic        run;
   logic        shc_ff;
   logic        shd_ff;
   logic [31:0] hold_ff;
   logic [31:0] disc_ff;
   logic [31:0] eoc_ff;
   logic        sleep_ff;
   logic        was_chg_ff;
   logic [31:0] low_cnt_ff;
   logic        low_armed_ff;
   logic [17:0] nxt_net_frac;
   logic [17:0] nxt_chg_frac;
   logic [17:0] nxt_dis_frac;
   logic [17:0] net_q;
   logic [17:0] net_r;
   logic [8:0]  net_up;
   logic [7:0]  nxt_net;

   assign current_converter_enable = config_byte[`BCA_CFG_CONV_BIT]; // (R20)
   assign lifetime_totals_enable   = config_byte[`BCA_CFG_TOT_BIT]; // (R21)
   assign totals_shadow_select     = config_byte[`BCA_CFG_SHAD_BIT];

   // Mode of the lifetime totals; shadowing needs totals enabled
   always_comb begin
      if (!lifetime_totals_enable)
         mode = bca_pkg::BCA_TOT_OFF; // (R09)
      else if (totals_shadow_select)
         mode = bca_pkg::BCA_TOT_SHADOW; // (R22)
      else
         mode = bca_pkg::BCA_TOT_VOLATILE; // (R10)
   end

   bca_sec_counter u_sec (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .osc_tick  (osc_tick),
      .seconds   (seconds),
      .sec_pulse (sec_pulse)
   );

   // Samples are taken only while awake and the converter is on
   assign run = sample_tick && current_converter_enable && !sleep_ff;
   assign pos = (sample_current > 10'sd0);
   assign neg = (sample_current < 10'sd0);
   assign mag = neg ? {8'h00, 10'(-sample_current)}
                    : {8'h00, 10'(sample_current)};

   // Remainders in units of one current count per sample
   always_comb begin
      nxt_net_frac = net_frac_ff;
      nxt_chg_frac = chg_frac_ff;
      nxt_dis_frac = dis_frac_ff;
      if (run && pos) begin
         nxt_net_frac = net_frac_ff + mag; // (R23)
         nxt_chg_frac = chg_frac_ff + mag;
      end
      if (run && neg) begin
         nxt_net_frac = net_frac_ff + mag;
         nxt_dis_frac = dis_frac_ff + mag;
      end
   end

   // One sample may span several net steps; quotient stays below 17
   assign net_q  = nxt_net_frac / `BCA_NET_STEP;
   assign net_r  = nxt_net_frac % `BCA_NET_STEP;
   assign net_up = {1'b0, net_ff} + net_q[8:0];

   always_comb begin
      nxt_net = net_ff;
      if (pos)
         nxt_net = net_up[8] ? `BCA_NET_MAX : net_up[7:0]; // (R03)
      else if (net_q[7:0] > net_ff)
         nxt_net = 8'h00; // (R02)
      else
         nxt_net = net_ff - net_q[7:0];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         net_frac_ff <= 18'h00000;
         net_ff      <= `BCA_NET_FULL;
      end else if (net_load) begin
         net_ff      <= net_load_val; // (R04)
         net_frac_ff <= 18'h00000;
      end else if (run && (pos || neg)) begin // (R05)
         net_frac_ff <= net_r; // (R23)
         net_ff      <= nxt_net; // (R01)
      end
   end

   // Lifetime totals do not depend on the net counter level
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         chg_ff      <= 16'h0000;
         chg_frac_ff <= 18'h00000;
         shc_ff      <= 1'b0;
      end else begin
         shc_ff <= 1'b0;
         if (chg_load) begin
            chg_ff <= chg_load_val;
         end else if (run && pos && mode != bca_pkg::BCA_TOT_OFF) begin
            if (nxt_chg_frac >= `BCA_TOT_STEP) begin // (R06)
               chg_frac_ff <= nxt_chg_frac - `BCA_TOT_STEP;
               if (chg_ff != `BCA_TOT_MAX) begin
                  chg_ff <= chg_ff + 16'h0001; // (R01)
                  shc_ff <= (mode == bca_pkg::BCA_TOT_SHADOW); // (R11)
               end
            end else begin
               chg_frac_ff <= nxt_chg_frac;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dis_ff      <= 16'h0000;
         dis_frac_ff <= 18'h00000;
         shd_ff      <= 1'b0;
      end else begin
         shd_ff <= 1'b0;
         if (dis_load) begin
            dis_ff <= dis_load_val;
         end else if (run && neg && mode != bca_pkg::BCA_TOT_OFF) begin
            if (nxt_dis_frac >= `BCA_TOT_STEP) begin // (R07)
               dis_frac_ff <= nxt_dis_frac - `BCA_TOT_STEP;
               if (dis_ff != `BCA_TOT_MAX) begin
                  dis_ff <= dis_ff + 16'h0001; // (R13)
                  shd_ff <= (mode == bca_pkg::BCA_TOT_SHADOW); // (R08)
               end
            end else begin
               dis_frac_ff <= nxt_dis_frac;
            end
         end
      end
   end

   // Snapshot for stable reads while counting goes on
   always_ff @(posedge clk_sys) begin
      if (rst)
         hold_ff <= 32'h00000000;
      else if (recall_bit8)
         hold_ff <= seconds; // (R15)
   end

   // Disconnect detect: line low for more than one second of oscillator
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         low_cnt_ff   <= 32'h00000000;
         low_armed_ff <= 1'b0;
         disc_ff      <= 32'h00000000;
         sleep_ff     <= 1'b0;
      end else if (line_in) begin
         low_cnt_ff   <= 32'h00000000;
         low_armed_ff <= 1'b0;
         sleep_ff     <= 1'b0;
      end else if (!sleep_ff && osc_tick) begin // (R14)
         low_cnt_ff <= low_cnt_ff + 32'h00000001;
         if (low_cnt_ff == 32'(`BCA_DISC_SEC * `BCA_OSC_DIV))
            low_armed_ff <= 1'b1;
         if (low_armed_ff) begin
            disc_ff  <= seconds; // (R17)
            sleep_ff <= 1'b1; // (R18)
         end
      end
   end

   // End of charge when a charging sample is followed by discharge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         was_chg_ff <= 1'b0;
         eoc_ff     <= 32'h00000000;
      end else if (run && (pos || neg)) begin
         was_chg_ff <= pos;
         if (was_chg_ff && neg)
            eoc_ff <= seconds; // (R19)
      end
   end

   assign net_capacity_counter     = net_ff;
   assign lifetime_charge_total    = chg_ff;
   assign lifetime_discharge_total = dis_ff;
   assign shadow_charge_req        = shc_ff;
   assign shadow_discharge_req     = shd_ff;
   assign seconds_live             = seconds;
   assign seconds_hold             = hold_ff;
   assign disconnect_stamp         = disc_ff;
   assign end_charge_stamp         = eoc_ff;
   assign sleeping                 = sleep_ff;

   property p_net_hold;
      @(posedge clk_sys) disable iff (rst)
         (!current_converter_enable && !net_load) |=> $stable(net_ff);
   endproperty
   a_net_hold: assert property (p_net_hold) // (R05)
      else $error("net counter moved while converter disabled");

   property p_net_sat;
      @(posedge clk_sys) disable iff (rst)
         (net_ff == 8'hFF && !net_load && !(run && neg)) |=> net_ff == 8'hFF;
   endproperty
   a_net_sat: assert property (p_net_sat) // (R03)
      else $error("net counter wrapped past top");

   property p_off_no_tot;
      @(posedge clk_sys) disable iff (rst)
         (!lifetime_totals_enable && !chg_load) |=> $stable(chg_ff);
   endproperty
   a_off_no_tot: assert property (p_off_no_tot) // (R09)
      else $error("charge total moved while disabled");

   property p_vol_no_shadow;
      @(posedge clk_sys) disable iff (rst)
         !totals_shadow_select |=> !shc_ff && !shd_ff;
   endproperty
   a_vol_no_shadow: assert property (p_vol_no_shadow) // (R10)
      else $error("shadow request without shadow mode");

   property p_shadow_step;
      @(posedge clk_sys) disable iff (rst)
         shc_ff |-> chg_ff == $past(chg_ff) + 16'h0001;
   endproperty
   a_shadow_step: assert property (p_shadow_step) // (R11)
      else $error("shadow request not tied to a step");

   property p_chg_pos;
      @(posedge clk_sys) disable iff (rst)
         (!(run && pos) && !chg_load) |=> $stable(chg_ff);
   endproperty
   a_chg_pos: assert property (p_chg_pos) // (R06)
      else $error("charge total moved without charging");

   property p_dis_neg;
      @(posedge clk_sys) disable iff (rst)
         (!(run && neg) && !dis_load) |=> $stable(dis_ff);
   endproperty
   a_dis_neg: assert property (p_dis_neg) // (R07)
      else $error("discharge total moved without discharge");

   property p_hold;
      @(posedge clk_sys) disable iff (rst)
         recall_bit8 |=> hold_ff == $past(seconds);
   endproperty
   a_hold: assert property (p_hold) // (R15)
      else $error("holding copy not taken");

   property p_sleep;
      @(posedge clk_sys) disable iff (rst)
         $rose(sleep_ff) |-> disc_ff == $past(seconds) && !line_in;
   endproperty
   a_sleep: assert property (p_sleep) // (R17)
      else $error("sleep without disconnect stamp");

   property p_net_floor;
      @(posedge clk_sys) disable iff (rst)
         (net_ff == 8'h00 && !net_load && !(run && pos)) |=> net_ff == 8'h00;
   endproperty
   a_net_floor: assert property (p_net_floor) // (R02)
      else $error("net counter wrapped below empty");

   property p_shd_step;
      @(posedge clk_sys) disable iff (rst)
         shd_ff |-> dis_ff == $past(dis_ff) + 16'h0001;
   endproperty
   a_shd_step: assert property (p_shd_step) // (R08)
      else $error("discharge shadow request not tied to a step");

   property p_eoc;
      @(posedge clk_sys) disable iff (rst)
         (run && was_chg_ff && neg) |=> eoc_ff == $past(seconds);
   endproperty
   a_eoc: assert property (p_eoc) // (R19)
      else $error("end of charge not stamped on reversal");

   property p_sleep_halt;
      @(posedge clk_sys) disable iff (rst)
         (sleep_ff && !net_load && !chg_load && !dis_load)
            |=> $stable(net_ff) && $stable(chg_ff) && $stable(dis_ff);
   endproperty
   a_sleep_halt: assert property (p_sleep_halt) // (R18)
      else $error("counters moved while asleep");

   property p_chg_top;
      @(posedge clk_sys) disable iff (rst)
         (chg_ff == 16'hFFFF && !chg_load) |=> chg_ff == 16'hFFFF;
   endproperty
   a_chg_top: assert property (p_chg_top) // (R06)
      else $error("charge total wrapped past top");
endmodule
`default_nettype wire

/* File: testbench/bca_host_model.sv */
`default_nettype none
module bca_host_model (
   input  wire logic        clk_sys,
   output logic [7:0]       config_byte,
   output logic             line_in,
   output logic             recall_bit8,
   output logic             net_load,
   output logic [7:0]       net_load_val,
   output logic             chg_load,
   output logic [15:0]      chg_load_val,
   output logic             dis_load,
   output logic [15:0]      dis_load_val
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      config_byte  = 8'h00;
      line_in      = 1'b1;
      recall_bit8  = 1'b0;
      {net_load, chg_load, dis_load} = 3'h0;
      net_load_val = 8'h00;
      chg_load_val = 16'h0000;
      dis_load_val = 16'h0000;
   end
   task automatic set_cfg(input logic [7:0] v);
      @(posedge clk_sys);
      config_byte <= v;
   endtask
   // Whole-counter loads only; no byte writes into the totals page
   task automatic load(input int w, input logic [15:0] v);
      @(posedge clk_sys);
      net_load     <= (w == 0);
      chg_load     <= (w == 1);
      dis_load     <= (w == 2);
      net_load_val <= v[7:0];
      chg_load_val <= v;
      dis_load_val <= v;
      @(posedge clk_sys);
      {net_load, chg_load, dis_load} <= 3'h0;
      {net_load_val, chg_load_val, dis_load_val} <= ~{v[7:0], v, v};
   endtask
   task automatic recall();
      @(posedge clk_sys);
      recall_bit8 <= 1'b1;
      @(posedge clk_sys);
      recall_bit8 <= 1'b0;
   endtask
   task automatic set_line(input logic v);
      @(posedge clk_sys);
      line_in <= v;
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_bca_accum.sv */
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_bca_accum;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clk_sys, rst, sample_tick, osc_tick;
   logic signed [9:0]  sample_current;
   logic [7:0]         config_byte, net_load_val, net;
   logic               line_in, recall_bit8, net_load, chg_load, dis_load;
   logic [15:0]        chg_load_val, dis_load_val, chg, dis;
   logic               sh_c, sh_d, sleeping;
   logic [31:0]        live, hold, disc, eoc, e_v, g_v;
   int                 n_errors, cmp_count, n_shc, n_shd, seed;
   string              q_nm[$], nm_v;
   int                 q_sel[$];
   logic [31:0]        q_exp[$];
   bca_accum i_bca_accum (.clk_sys(clk_sys), .rst(rst),
      .sample_tick(sample_tick), .sample_current(sample_current),
      .config_byte(config_byte), .osc_tick(osc_tick), .line_in(line_in),
      .recall_bit8(recall_bit8), .net_load(net_load),
      .net_load_val(net_load_val), .chg_load(chg_load),
      .chg_load_val(chg_load_val), .dis_load(dis_load),
      .dis_load_val(dis_load_val), .net_capacity_counter(net),
      .lifetime_charge_total(chg), .lifetime_discharge_total(dis),
      .shadow_charge_req(sh_c), .shadow_discharge_req(sh_d),
      .seconds_live(live), .seconds_hold(hold), .disconnect_stamp(disc),
      .end_charge_stamp(eoc), .sleeping(sleeping));
   bca_host_model i_bca_host_model (.clk_sys(clk_sys),
      .config_byte(config_byte), .line_in(line_in),
      .recall_bit8(recall_bit8), .net_load(net_load),
      .net_load_val(net_load_val), .chg_load(chg_load),
      .chg_load_val(chg_load_val), .dis_load(dis_load),
      .dis_load_val(dis_load_val));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (rst) begin
         n_shc <= 0;
         n_shd <= 0;
      end else begin
         n_shc <= n_shc + (sh_c === 1'b1);
         n_shd <= n_shd + (sh_d === 1'b1);
      end
   end
   function automatic logic [31:0] obs(input int s);
      case (s)
         0: return {24'h0, net};
         1: return {16'h0, chg};
         2: return {16'h0, dis};
         3: return live;
         4: return hold;
         5: return disc;
         6: return eoc;
         7: return {31'h0, sleeping};
         8: return n_shc;
         default: return n_shd;
      endcase
   endfunction
   // Every queued note is compared, oldest first, once the outputs have settled
   always @(negedge clk_sys) begin
      while (q_sel.size() > 0) begin
         nm_v = q_nm.pop_front();
         e_v = q_exp.pop_front();
         g_v = obs(q_sel.pop_front());
         `CHK(nm_v, e_v, g_v)
      end
   end
   task automatic note(input string nm, input int s, input logic [31:0] e);
      q_nm.push_back(nm);
      q_sel.push_back(s);
      q_exp.push_back(e);
   endtask
   task automatic samp(input int n, input logic signed [9:0] v);
      repeat (n) begin
         @(posedge clk_sys);
         sample_tick <= 1'b1;
         sample_current <= v;
         // Idle gap with noise on the current input
         @(posedge clk_sys);
         sample_tick <= 1'b0;
         sample_current <= 10'($random(seed));
      end
      @(posedge clk_sys);
      sample_tick <= 1'b0;
      sample_current <= ~v;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic osc(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         osc_tick <= 1'b1;
      end
      @(posedge clk_sys);
      osc_tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk_sys);
      n_errors++;
      results();
   end
   initial begin
      seed = 47;
      rst = 1'b1;
      {sample_tick, osc_tick} = 2'h0;
      sample_current = 10'sd0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      note("net", 0, 32'h64);
      note("chg", 1, 32'h0);
      osc(32768);
      note("live", 3, 32'h1);
      i_bca_host_model.recall();
      repeat (2) @(posedge clk_sys);
      note("hold", 4, 32'h1);
      $display("test time done");
      i_bca_host_model.set_cfg({5'($random(seed)), 3'h7});
      samp(14, 10'sd481);
      note("net", 0, 32'hFF);
      note("chg", 1, 32'h2);
      note("shc", 8, 32'h2);
      i_bca_host_model.load(0, 16'h0064);
      repeat (2) @(posedge clk_sys);
      note("net", 0, 32'h64);
      i_bca_host_model.set_cfg({5'($random(seed)), 3'h6});
      samp(1, 10'($random(seed)));
      note("net", 0, 32'h64);
      note("chg", 1, 32'h2);
      $display("test charge done");
      i_bca_host_model.set_cfg({5'($random(seed)), 3'h7});
      i_bca_host_model.load(0, 16'h0005);
      i_bca_host_model.load(2, 16'h0010);
      samp(14, -10'sd481);
      note("net", 0, 32'h0);
      note("dis", 2, 32'h12);
      note("chg", 1, 32'h2);
      note("shd", 9, 32'h2);
      note("eoc", 6, 32'h1);
      $display("test discharge done");
      i_bca_host_model.set_cfg({5'($random(seed)), 3'h1});
      samp(14, 10'sd481);
      note("chg", 1, 32'h2);
      i_bca_host_model.set_cfg({5'($random(seed)), 3'h3});
      i_bca_host_model.load(1, 16'hFFFF);
      samp(7, 10'sd481);
      note("chg", 1, 32'hFFFF);
      samp(7, -10'sd481);
      note("dis", 2, 32'h13);
      note("shc", 8, 32'h2);
      note("shd", 9, 32'h2);
      $display("test modes done");
      i_bca_host_model.load(0, 16'h0032);
      i_bca_host_model.set_line(1'b0);
      osc(32770);
      note("sleep", 7, 32'h1);
      note("disc", 5, 32'h2);
      samp(3, 10'sd33);
      note("net", 0, 32'h32);
      note("live", 3, 32'h2);
      note("hold", 4, 32'h1);
      i_bca_host_model.set_line(1'b1);
      repeat (3) @(posedge clk_sys);
      note("sleep", 7, 32'h0);
      $display("test disconnect done");
      repeat (3) @(posedge clk_sys);
      results();
   end
endmodule
`default_nettype wire
